/* hw/sma_auth_cmd.v */
// How it works
// - kind bit: 0 write password, 1 read password; set bit picks stored set
// - kind and set equal to 01 selects the secure code
// - first verify password only writes a new zero counter bit
// - second verify password compares three bytes, clears counter on match
// - verify password plus stop starts a nonvolatile write cycle
// - poll byte bd is answered after the write, returning the counter
// - counter shows one more zero after pass one, all ones after success
// - init authentication loads generator from cryptogram, seed, host random
// - init authentication stop runs write clearing one more counter bit
// - challenge equal cryptogram plus one stores cryptogram plus two
// - verify authentication stop runs write; host polls bd for outcome
// - valid authentication sets the auth counter to all ones
// - invalid authentication writes but leaves the auth counter
// - data changes only with clock low; else start or stop
// - data falling with clock high is a start before every command
// - data rising with clock high is a stop; after read goes standby
// - eight-bit words, device pulls data low on ninth clock to acknowledge
// - standby at power-up and after stop once operations are done
// - inputs ignored during write; poll acknowledged only after completion
// - all bytes travel most significant bit first
// - exhausted counter makes further attempts on it ignored
// - one verified password active until reset or another is presented
`include "sma_consts.vh"

module sma_auth_cmd #(
    parameter WR_CYCLES = `SMA_WR_CYCLES
) (
    // clock and reset
    input wire ref_clk_i,
    input wire rst_b_i,
    // two-wire link pins
    input wire scl_i,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe_b_o,
    // configuration
    input wire [3:0] chip_sel_i,
    input wire [23:0] pw_write0_i,
    input wire [23:0] pw_write1_i,
    input wire [23:0] pw_read0_i,
    input wire [23:0] pw_read1_i,
    input wire [63:0] secret_seed_i,
    // status
    output wire standby_o,
    output wire write_busy_o,
    output reg pw_active_o,
    output reg [1:0] pw_active_sel_o,
    output wire secure_code_ok_o,
    output reg auth_ok_o,
    output reg [63:0] card_cryptogram_o,
    output reg [63:0] rng_state_o,
    output reg [31:0] password_attempt_counter_o,
    output reg [7:0] auth_attempt_counter_o
);

localparam ST_IDLE = 3'h0;
localparam ST_CMD = 3'h1;
localparam ST_RX = 3'h2;
localparam ST_TX = 3'h3;
localparam ST_WAIT = 3'h4;

localparam OP_NONE = 2'h0;
localparam OP_VPW = 2'h1;
localparam OP_IAUTH = 2'h2;
localparam OP_VAUTH = 2'h3;

localparam [`SMA_WR_CNT_W-1:0] WR_LOAD = WR_CYCLES[`SMA_WR_CNT_W-1:0];

wire scl_lvl;
wire scl_rise;
wire scl_fall;
wire sda_lvl;
wire sda_rise;
wire sda_fall;

reg [2:0] state_r;
reg [3:0] bit_cnt_r;
reg [3:0] byte_cnt_r;
reg [3:0] need_r;
reg [7:0] shift_r;
reg [63:0] data_r;
reg [1:0] op_r;
reg [1:0] sel_r;
reg done_r;
reg drive_r;
reg [7:0] tx_byte_r;
reg host_ack_r;
reg [`SMA_WR_CNT_W-1:0] wr_cnt_r;
reg pw_armed_r;
reg [1:0] armed_sel_r;
reg auth_armed_r;
reg last_is_auth_r;
reg [1:0] last_sel_r;

reg [23:0] pw_ref;
reg [7:0] pac_sel;
reg [7:0] poll_byte;

// both link pins come from outside this clock domain
sma_pin_sync #(.RST_LEVEL(1'b0)) u_scl_sync ( // the link clock idles low
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .pin_i(scl_i),
    .level_o(scl_lvl),
    .rise_o(scl_rise),
    .fall_o(scl_fall)
);

sma_pin_sync u_sda_sync (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .pin_i(sda_i),
    .level_o(sda_lvl),
    .rise_o(sda_rise),
    .fall_o(sda_fall)
);

wire start_det = scl_lvl & sda_fall;
wire stop_det = scl_lvl & sda_rise;
wire busy = (wr_cnt_r != {`SMA_WR_CNT_W{1'b0}});
wire [7:0] byte_in = shift_r;

// open drain: only ever pulls low
assign sda_o = 1'b0;
assign sda_oe_b_o = ~drive_r;
assign write_busy_o = busy;
assign standby_o = (state_r == ST_IDLE) & ~busy;
assign secure_code_ok_o = pw_active_o & (pw_active_sel_o == `SMA_SEL_SECURE);

// stored password and counter for the selected kind and set
always @*
begin
    case (sel_r)
        2'h0: pw_ref = pw_write0_i;
        2'h1: pw_ref = pw_write1_i;
        2'h2: pw_ref = pw_read0_i;
        default: pw_ref = pw_read1_i;
    endcase
    pac_sel = password_attempt_counter_o[sel_r*8 +: 8];
    if (last_is_auth_r)
        poll_byte = auth_attempt_counter_o;
    else
        poll_byte = password_attempt_counter_o[last_sel_r*8 +: 8];
end

// link framing, command decode and nonvolatile commit
always @(posedge ref_clk_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        state_r <= ST_IDLE;
        bit_cnt_r <= 4'h0;
        byte_cnt_r <= 4'h0;
        need_r <= 4'h0;
        shift_r <= 8'h00;
        data_r <= 64'h0;
        op_r <= OP_NONE;
        sel_r <= 2'h0;
        done_r <= 1'b0;
        drive_r <= 1'b0;
        tx_byte_r <= 8'h00;
        host_ack_r <= 1'b0;
        wr_cnt_r <= {`SMA_WR_CNT_W{1'b0}};
        pw_armed_r <= 1'b0;
        armed_sel_r <= 2'h0;
        auth_armed_r <= 1'b0;
        last_is_auth_r <= 1'b0;
        last_sel_r <= 2'h0;
        pw_active_o <= 1'b0;
        pw_active_sel_o <= 2'h0;
        auth_ok_o <= 1'b0;
        card_cryptogram_o <= `SMA_CRYPT_RST;
        rng_state_o <= 64'h0;
        password_attempt_counter_o <= {4{`SMA_CTR_RST}};
        auth_attempt_counter_o <= `SMA_CTR_RST;
    end
    else
    begin
        // self-timed write cycle runs down on its own
        if (busy)
            wr_cnt_r <= wr_cnt_r - 1'b1;
        if (start_det)
        begin
            // a start aborts any frame and always releases the line
            state_r <= ST_CMD;
            bit_cnt_r <= 4'h0;
            byte_cnt_r <= 4'h0;
            done_r <= 1'b0;
            drive_r <= 1'b0;
        end
        else if (stop_det)
        begin
            state_r <= ST_IDLE;
            drive_r <= 1'b0;
            if (done_r && !busy)
            begin
                done_r <= 1'b0;
                case (op_r)
                    OP_VPW:
                    begin
                        if (pac_sel != `SMA_CTR_EXHAUSTED)
                        begin
                            wr_cnt_r <= WR_LOAD;
                            last_is_auth_r <= 1'b0;
                            last_sel_r <= sel_r;
                            pw_active_o <= 1'b0;
                            if (pw_armed_r && armed_sel_r == sel_r)
                            begin
                                pw_armed_r <= 1'b0;
                                if (data_r[23:0] == pw_ref)
                                begin
                                    password_attempt_counter_o[sel_r*8 +: 8] <=
                                        `SMA_CTR_RST;
                                    pw_active_o <= 1'b1;
                                    pw_active_sel_o <= sel_r;
                                end
                                // a failed compare keeps the bit of pass one
                            end
                            else
                            begin
                                // first pass: data ignored, one more zero bit
                                password_attempt_counter_o[sel_r*8 +: 8] <=
                                    {pac_sel[6:0], 1'b0};
                                pw_armed_r <= 1'b1;
                                armed_sel_r <= sel_r;
                            end
                        end
                    end
                    OP_IAUTH:
                    begin
                        pw_armed_r <= 1'b0;
                        if (auth_attempt_counter_o != `SMA_CTR_EXHAUSTED)
                        begin
                            wr_cnt_r <= WR_LOAD;
                            last_is_auth_r <= 1'b1;
                            auth_attempt_counter_o <=
                                {auth_attempt_counter_o[6:0], 1'b0};
                            rng_state_o <= card_cryptogram_o ^ secret_seed_i ^ data_r;
                            auth_armed_r <= 1'b1;
                            auth_ok_o <= 1'b0;
                        end
                    end
                    OP_VAUTH:
                    begin
                        pw_armed_r <= 1'b0;
                        if (auth_attempt_counter_o != `SMA_CTR_EXHAUSTED)
                        begin
                            wr_cnt_r <= WR_LOAD;
                            last_is_auth_r <= 1'b1;
                            auth_armed_r <= 1'b0;
                            auth_ok_o <= 1'b0;
                            // only valid after an init authentication with no verify authentication since
                            if (auth_armed_r && data_r == card_cryptogram_o + 64'h1)
                            begin
                                card_cryptogram_o <= card_cryptogram_o + 64'h2;
                                auth_attempt_counter_o <= `SMA_CTR_RST;
                                auth_ok_o <= 1'b1;
                            end
                        end
                    end
                    default: ;
                endcase
            end
        end
        else if (scl_rise && state_r != ST_IDLE && state_r != ST_WAIT)
        begin
            // sample on the rising clock, msb first
            if (bit_cnt_r < 4'h8)
                shift_r <= {shift_r[6:0], sda_lvl};
            else if (state_r == ST_TX)
                host_ack_r <= ~sda_lvl;
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end
        else if (scl_fall && state_r != ST_IDLE && state_r != ST_WAIT)
        begin
            if (bit_cnt_r == 4'h8)
            begin
                // byte just completed: decide on the ninth clock
                drive_r <= 1'b0;
                case (state_r)
                    ST_CMD:
                    begin
                        if (busy)
                            state_r <= ST_WAIT;
                        else if (byte_in == `SMA_CMD_POLL_READ)
                        begin
                            drive_r <= 1'b1;
                            tx_byte_r <= poll_byte;
                            host_ack_r <= 1'b1;
                            state_r <= ST_TX;
                        end
                        else if (byte_in[`SMA_CS_HI:`SMA_CS_LO] != chip_sel_i)
                            state_r <= ST_WAIT;
                        else if (byte_in[1:0] == `SMA_INS_VERIFY_PW)
                        begin
                            drive_r <= 1'b1;
                            op_r <= OP_VPW;
                            sel_r <= {byte_in[`SMA_KIND_BIT], byte_in[`SMA_SET_BIT]};
                            need_r <= `SMA_PW_BYTES;
                            state_r <= ST_RX;
                        end
                        else if (byte_in[3:0] == `SMA_INS_INIT_AUTH)
                        begin
                            drive_r <= 1'b1;
                            op_r <= OP_IAUTH;
                            need_r <= `SMA_AUTH_BYTES;
                            state_r <= ST_RX;
                        end
                        else if (byte_in[3:0] == `SMA_INS_VERIFY_AUTH)
                        begin
                            drive_r <= 1'b1;
                            op_r <= OP_VAUTH;
                            need_r <= `SMA_AUTH_BYTES;
                            state_r <= ST_RX;
                        end
                        else
                            state_r <= ST_WAIT; // other commands live elsewhere
                    end
                    ST_RX:
                    begin
                        if (done_r)
                            state_r <= ST_WAIT; // surplus bytes are not acknowledged
                        else
                        begin
                            drive_r <= 1'b1;
                            data_r <= {data_r[55:0], byte_in};
                            byte_cnt_r <= byte_cnt_r + 4'h1;
                            if (byte_cnt_r + 4'h1 == need_r)
                                done_r <= 1'b1;
                        end
                    end
                    default: ; // transmit: host owns the ninth clock
                endcase
            end
            else if (bit_cnt_r == 4'h9)
            begin
                bit_cnt_r <= 4'h0;
                if (state_r == ST_TX && host_ack_r)
                    drive_r <= ~tx_byte_r[7];
                else if (state_r == ST_TX)
                begin
                    drive_r <= 1'b0; // no-acknowledge ends the read
                    state_r <= ST_WAIT;
                end
                else
                    drive_r <= 1'b0;
            end
            else if (state_r == ST_TX)
                drive_r <= ~tx_byte_r[3'h7 - bit_cnt_r[2:0]];
        end
    end
end

endmodule // sma_auth_cmd

/* hw/sma_consts.vh */
`ifndef SMA_CONSTS_VH
`define SMA_CONSTS_VH

// clock and self-timed write cycle
`define SMA_CLK_MHZ 100
`define SMA_WR_TIME_MS 10
`define SMA_WR_CYCLES (`SMA_WR_TIME_MS * `SMA_CLK_MHZ * 1000)
`define SMA_WR_CNT_W 20

// command byte fields
`define SMA_CS_HI 7
`define SMA_CS_LO 4
`define SMA_KIND_BIT 3
`define SMA_SET_BIT 2
`define SMA_CMD_POLL_READ 8'hbd
`define SMA_INS_VERIFY_PW 2'h3
`define SMA_INS_INIT_AUTH 4'h2
`define SMA_INS_VERIFY_AUTH 4'h6

// password select codes (kind, set)
`define SMA_SEL_SECURE 2'h1

// data byte counts
`define SMA_PW_BYTES 4'h3
`define SMA_AUTH_BYTES 4'h8

// reset values and the exhausted counter value
`define SMA_CTR_RST 8'hff
`define SMA_CTR_EXHAUSTED 8'h00
`define SMA_CRYPT_RST 64'h0000000000000000

`endif

/* hw/sma_pin_sync.v */
// two-flop synchroniser with a third stage for edge detection
module sma_pin_sync #(
    // level the pin rests at while the bus is idle
    parameter [0:0] RST_LEVEL = 1'b1
) (
    // clock and reset
    input wire ref_clk_i,
    input wire rst_b_i,
    // pin in
    input wire pin_i,
    // synchronised level and edges
    output wire level_o,
    output wire rise_o,
    output wire fall_o
);

reg meta_r;
reg sync_r;
reg last_r;

// reset to the pin's idle level, so no false edge follows reset
always @(posedge ref_clk_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        meta_r <= RST_LEVEL;
        sync_r <= RST_LEVEL;
        last_r <= RST_LEVEL;
    end
    else
    begin
        meta_r <= pin_i;
        sync_r <= meta_r;
        last_r <= sync_r;
    end
end

// edges look at the second and third stage only
assign level_o = sync_r;
assign rise_o = sync_r & ~last_r;
assign fall_o = ~sync_r & last_r;

endmodule // sma_pin_sync

/* test/sma_auth_cmd_bench.sv */
`include "sma_consts.vh"
module sma_auth_cmd_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WR = 400;
    localparam logic [23:0] PW [4] = '{24'h123456, 24'h5a5a5a, 24'hfedcba, 24'h0f0f0f};
    localparam logic [63:0] SEED = 64'h0123456789abcdef;
    localparam logic [63:0] RND = 64'h1122334455667788;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] chip_sel = 4'ha;
    wire scl, sda, hs, sda_o, oe_b, standby_o, write_busy_o, pw_active_o, secure_ok, auth_ok_o;
    wire [1:0] act_sel;
    wire [63:0] crypt, rng;
    wire [31:0] password_attempt_counter;
    wire [7:0] aac;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;

    // open drain: pulled high, low when either side pulls
    assign sda = hs & (oe_b | sda_o);

    sma_auth_cmd #(.WR_CYCLES(WR)) u_sma_auth_cmd (
        .ref_clk_i(clk), .rst_b_i(rst_b), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_b_o(oe_b), .chip_sel_i(chip_sel), .pw_write0_i(PW[0]), .pw_write1_i(PW[1]),
        .pw_read0_i(PW[2]), .pw_read1_i(PW[3]), .secret_seed_i(SEED),
        .standby_o(standby_o), .write_busy_o(write_busy_o), .pw_active_o(pw_active_o),
        .pw_active_sel_o(act_sel), .secure_code_ok_o(secure_ok), .auth_ok_o(auth_ok_o),
        .card_cryptogram_o(crypt), .rng_state_o(rng),
        .password_attempt_counter_o(password_attempt_counter), .auth_attempt_counter_o(aac));

    sma_host_model u_sma_host_model (.ref_clk_i(clk), .scl_o(scl), .sda_o(hs), .sda_i(sda));

    always #5 clk = ~clk;

    task automatic stop_test();
        if (n_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // hang guard, well above the expected run
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            n_errors++;
            stop_test();
        end
    end

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // whole frame: start, command, n data bytes msb first, stop
    task automatic frame(input logic [7:0] c, input int n, input logic [63:0] v, output logic ack);
        logic a;
        u_sma_host_model.start();
        u_sma_host_model.send(c, ack);
        for (int i = n - 1; i >= 0; i--)
            u_sma_host_model.send(v[i*8 +: 8], a);
        u_sma_host_model.stop();
    endtask

    task automatic idle();
        int k;
        k = 0;
        while (write_busy_o !== 1'b0 && k < 2000)
        begin
            @(posedge clk);
            k++;
        end
        chk("busy end", 1'b0, write_busy_o);
    endtask

    // refused while busy, then answered with the counter
    task automatic poll(input logic [7:0] exp);
        logic a;
        logic [7:0] d;
        frame(`SMA_CMD_POLL_READ, 0, 64'h0, a);
        chk("busy poll ack", 1'b0, a);
        idle();
        u_sma_host_model.start();
        u_sma_host_model.send(`SMA_CMD_POLL_READ, a);
        chk("poll ack", 1'b1, a);
        u_sma_host_model.recv(1'b0, d);
        u_sma_host_model.stop();
        chk("counter", exp, d);
        repeat (8) @(posedge clk);
        chk("standby", 1'b1, standby_o);
    endtask

    task automatic t_reset();
        chk("standby", 1'b1, standby_o);
        chk("oe", 1'b1, oe_b);
        chk("counters", 40'hffffffffff, {password_attempt_counter, aac});
        chk("crypt", 64'h0, crypt);
    endtask

    // reset in mid-run drops the active password, then idles as at power-up
    task automatic t_mid_reset();
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        chk("reset active", 1'b0, pw_active_o);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
    endtask

    // every kind and set, init pass with junk data then the real one
    task automatic t_password();
        logic a;
        for (int s = 0; s < 4; s++)
        begin
            frame({chip_sel, s[1:0], 2'b11}, 3, {40'h0, ~PW[s]}, a);
            chk("vp ack", 1'b1, a);
            poll(8'hfe);
            frame({chip_sel, s[1:0], 2'b11}, 3, {40'h0, PW[s]}, a);
            poll(8'hff);
            chk("active", 1'b1, pw_active_o);
            chk("sel", s[1:0], act_sel);
            chk("secure", s == 1, secure_ok);
        end
    endtask

    task automatic t_bad_password();
        logic a;
        frame({chip_sel, 2'h2, 2'b11}, 3, 64'h0, a);
        poll(8'hfe);
        frame({chip_sel, 2'h2, 2'b11}, 3, 64'h0, a);
        idle();
        chk("active", 1'b0, pw_active_o);
        chk("bit kept", 1'b0, password_attempt_counter[16]);
    endtask

    task automatic t_auth();
        logic a;
        chip_sel <= 4'hb;
        frame(8'hb2, 8, RND, a);
        chk("init ack", 1'b1, a);
        chk("rng", SEED ^ RND, rng);
        frame(8'hb6, 0, 64'h0, a);
        chk("busy b6", 1'b0, a);
        idle();
        frame(8'hb6, 8, 64'h1, a);
        chk("verify ack", 1'b1, a);
        poll(8'hff);
        chk("crypt", 64'h2, crypt);
        chk("auth ok", 1'b1, auth_ok_o);
    endtask

    task automatic t_bad_auth();
        logic a;
        frame(8'hb2, 8, RND, a);
        chk("rng", 64'h2 ^ SEED ^ RND, rng);
        idle();
        frame(8'hb6, 8, 64'h5, a);
        repeat (8) @(posedge clk);
        chk("busy", 1'b1, write_busy_o);
        idle();
        chk("auth ok", 1'b0, auth_ok_o);
        chk("not cleared", 1'b0, aac[0]);
        chk("crypt", 64'h2, crypt);
    endtask

    // seven more init passes use up the auth counter; later attempts are ignored
    task automatic t_exhaust();
        logic a;
        for (int i = 0; i < 7; i++)
        begin
            frame(8'hb2, 8, RND, a);
            idle();
        end
        chk("aac empty", 8'h00, aac);
        frame(8'hb2, 8, 64'h0, a);
        repeat (8) @(posedge clk);
        chk("no write", 1'b0, write_busy_o);
        chk("rng kept", 64'h2 ^ SEED ^ RND, rng);
        frame(8'hb6, 8, 64'h3, a);
        repeat (8) @(posedge clk);
        chk("crypt kept", 64'h2, crypt);
        chk("auth ok kept", 1'b0, auth_ok_o);
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_password();
        t_mid_reset();
        t_bad_password();
        t_auth();
        t_bad_auth();
        t_exhaust();
        stop_test();
    end
endmodule // sma_auth_cmd_bench

/* test/sma_auth_cmd_props.sv */
module sma_auth_cmd_props #(
    parameter WR_CYCLES = 50
) (
    // clock and reset
    input wire ref_clk_i,
    input wire rst_b_i,
    // link pins
    input wire scl_i,
    input wire sda_i,
    input wire sda_oe_b_o,
    // status
    input wire standby_o,
    input wire write_busy_o,
    input wire pw_active_o,
    input wire [1:0] pw_active_sel_o,
    input wire secure_code_ok_o,
    input wire auth_ok_o,
    input wire [63:0] card_cryptogram_o,
    input wire [31:0] password_attempt_counter_o,
    input wire [7:0] auth_attempt_counter_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    reg [31:0] busy_cnt_r;

    // length of the write cycle, too long to unroll as a repetition
    always @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            busy_cnt_r <= 32'h0;
        else if (write_busy_o)
            busy_cnt_r <= busy_cnt_r + 32'h1;
        else
            busy_cnt_r <= 32'h0;
    end

    a_secure_code_sel: assert property
        (secure_code_ok_o == (pw_active_o && pw_active_sel_o == 2'h1))
        else $error("secure code flag wrong");
    a_busy_not_standby: assert property (write_busy_o |-> !standby_o)
        else $error("standby during write");
    a_ack_clock_low: assert property ($changed(sda_oe_b_o) |-> !scl_i)
        else $error("data moved with clock high");
    a_busy_no_ack: assert property (write_busy_o |-> sda_oe_b_o)
        else $error("drive during write");
    a_write_length: assert property ($fell(write_busy_o) |-> busy_cnt_r == WR_CYCLES)
        else $error("write cycle length wrong");
    a_write_at_stop: assert property
        ($rose(write_busy_o) |-> scl_i && sda_i)
        else $error("write not started by stop");
    a_auth_ctr_write: assert property
        ($changed(auth_attempt_counter_o) |-> ##[0:2] write_busy_o)
        else $error("auth counter changed without write");
    a_pw_ctr_write: assert property
        ($changed(password_attempt_counter_o) |-> ##[0:2] write_busy_o)
        else $error("password counter changed without write");
    a_crypt_plus_two: assert property
        ($changed(card_cryptogram_o) |-> card_cryptogram_o == $past(card_cryptogram_o) + 64'h2)
        else $error("cryptogram step wrong");
    a_auth_ok_clear: assert property
        ($rose(auth_ok_o) |-> auth_attempt_counter_o == 8'hff)
        else $error("auth ok without cleared counter");
endmodule // sma_auth_cmd_props

bind sma_auth_cmd sma_auth_cmd_props #(.WR_CYCLES(WR_CYCLES)) u_sma_auth_cmd_props (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .scl_i(scl_i), .sda_i(sda_i),
    .sda_oe_b_o(sda_oe_b_o), .standby_o(standby_o), .write_busy_o(write_busy_o),
    .pw_active_o(pw_active_o), .pw_active_sel_o(pw_active_sel_o),
    .secure_code_ok_o(secure_code_ok_o), .auth_ok_o(auth_ok_o),
    .card_cryptogram_o(card_cryptogram_o),
    .password_attempt_counter_o(password_attempt_counter_o),
    .auth_attempt_counter_o(auth_attempt_counter_o));

/* test/sma_host_model.sv */
module sma_host_model (
    // clock
    input wire ref_clk_i,
    // link pins
    output logic scl_o,
    output logic sda_o,
    input wire sda_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle: clock low, data released
    initial
    begin
        scl_o = 1'b0;
        sda_o = 1'b1;
    end

    // quarters of the 160 ns link period
    task automatic q(input int n);
        repeat (n * 4) @(posedge ref_clk_i);
    endtask

    // data falls under a high clock
    task automatic start();
        sda_o <= 1'b1;
        q(1);
        scl_o <= 1'b1;
        q(2);
        sda_o <= 1'b0;
        q(2);
        scl_o <= 1'b0;
        q(1);
    endtask

    // data rises under a high clock, clock back low
    task automatic stop();
        sda_o <= 1'b0;
        q(1);
        scl_o <= 1'b1;
        q(2);
        sda_o <= 1'b1;
        q(2);
        scl_o <= 1'b0;
        q(1);
    endtask

    // data set only while the clock is low
    task automatic pulse(input logic b, output logic s);
        sda_o <= b;
        q(1);
        scl_o <= 1'b1;
        q(1);
        s = sda_i;
        q(1);
        scl_o <= 1'b0;
        q(1);
    endtask

    // msb first, data released for the ninth clock
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            pulse(d[i], s);
        pulse(1'b1, s);
        ack = ~s;
    endtask

    // nack holds data high across the whole ninth clock
    task automatic recv(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            pulse(1'b1, s);
            d[i] = s;
        end
        pulse(~more, s);
    endtask
endmodule // sma_host_model
